// ---- design/swb_regs.sv ----
`include "swb_consts.svh"
`default_nettype none

module swb_regs
  import swb_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Register port
  input wire swb_reg_req_s i_req,
  output logic [15:0] o_rdata,
  // Register contents
  output swb_regset_s o_regs
);

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------

  // Only writable bits change; reserved bits keep zero
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_regs.ws_config <= `SWB_RST_WS_CONFIG;
      o_regs.ws_control <= `SWB_RST_WS_CONTROL;
      o_regs.bank_ctrl <= `SWB_RST_BANK_CTRL;
    end else if (i_req.wr) begin
      case (i_req.addr)
        `SWB_OFS_WS_CONFIG: begin
          o_regs.ws_config <= i_req.wdata & `SWB_WMASK_WS_CONFIG;
        end
        `SWB_OFS_WS_CONTROL: begin
          o_regs.ws_control <= i_req.wdata & `SWB_WMASK_WS_CONTROL;
        end
        `SWB_OFS_BANK_CTRL: begin
          o_regs.bank_ctrl <= i_req.wdata & `SWB_WMASK_BANK_CTRL;
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------

  // Registered read data, one cycle after the read strobe
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 16'h0000;
    end else if (i_req.rd) begin
      case (i_req.addr)
        `SWB_OFS_WS_CONFIG: o_rdata <= o_regs.ws_config;
        `SWB_OFS_WS_CONTROL: o_rdata <= o_regs.ws_control;
        `SWB_OFS_BANK_CTRL: o_rdata <= o_regs.bank_ctrl;
        default: o_rdata <= 16'h0000;
      endcase
    end
  end

endmodule // swb_regs

`default_nettype wire

// ---- design/swb_wait_bank.sv ----

`include "swb_consts.svh"
`default_nettype none

module swb_wait_bank
  import swb_pkg::*;
#(
  parameter int ADDR_W = 18
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Subsystem select pin, low grants A
  input wire logic i_subsys_sel,
  // Register port of subsystem A
  input wire swb_reg_req_s i_a_reg,
  output logic [15:0] o_a_rdata,
  // Register port of subsystem B
  input wire swb_reg_req_s i_b_reg,
  output logic [15:0] o_b_rdata,
  // Access request from the granted subsystem
  input wire swb_acc_s i_acc,
  output logic o_busy,
  output logic o_ack,
  output logic [15:0] o_rdata,
  // External bus
  output logic o_strobe,
  output logic o_idle_ins,
  output logic o_ext_write,
  output swb_space_e o_ext_space,
  output logic [ADDR_W-1:0] o_ext_addr,
  output logic [15:0] o_ext_wdata,
  input wire logic [15:0] i_ext_rdata
);

  // ----------------------------------------------------------------
  // Per-subsystem register sets
  // ----------------------------------------------------------------

  swb_regset_s regs_a;
  swb_regset_s regs_b;
  swb_regset_s regs_sel;

  swb_regs u_regs_a (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_req(i_a_reg),
    .o_rdata(o_a_rdata),
    .o_regs(regs_a)
  );

  swb_regs u_regs_b (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_req(i_b_reg),
    .o_rdata(o_b_rdata),
    .o_regs(regs_b)
  );

  // Granted subsystem governs waits and bank size
  assign regs_sel = i_subsys_sel ? regs_b : regs_a;

  // ----------------------------------------------------------------
  // Field extraction from the governing set
  // ----------------------------------------------------------------

  logic ext_range;
  logic mult;
  logic turn_en;
  logic [3:0] bank_mask;
  logic [2:0] base_io;
  logic [2:0] base_dhi;
  logic [2:0] base_dlo;
  logic [2:0] base_phi;
  logic [2:0] base_plo;

  // Field slices
  assign ext_range = regs_sel.ws_config[`SWB_CFG_EXTR_BIT];
  assign base_io = regs_sel.ws_config[`SWB_CFG_IO_MSB:`SWB_CFG_IO_LSB];
  assign base_dhi = regs_sel.ws_config[`SWB_CFG_DHI_MSB:`SWB_CFG_DHI_LSB];
  assign base_dlo = regs_sel.ws_config[`SWB_CFG_DLO_MSB:`SWB_CFG_DLO_LSB];
  assign base_phi = regs_sel.ws_config[`SWB_CFG_PHI_MSB:`SWB_CFG_PHI_LSB];
  assign base_plo = regs_sel.ws_config[`SWB_CFG_PLO_MSB:`SWB_CFG_PLO_LSB];
  assign mult = regs_sel.ws_control[`SWB_CTL_MULT_BIT];
  assign bank_mask = regs_sel.bank_ctrl[`SWB_BSC_CMP_MSB:`SWB_BSC_CMP_LSB];
  assign turn_en = regs_sel.bank_ctrl[`SWB_BSC_TURN_BIT];

  // ----------------------------------------------------------------
  // Wait count for the incoming access
  // ----------------------------------------------------------------

  logic [2:0] base_sel;
  logic [3:0] waits_raw;
  logic [3:0] waits_nxt;

  // Range decode picks one base count
  always_comb begin
    base_sel = base_plo;
    case (i_acc.space)
      SWB_SP_IO: base_sel = base_io;
      SWB_SP_DATA: begin
        if (i_acc.addr[`SWB_ADDR_HALF_BIT]) begin
          base_sel = base_dhi;
        end else begin
          base_sel = base_dlo;
        end
      end
      SWB_SP_PROG: begin
        // Extended range lets the lower field cover every page
        if (ext_range) begin
          base_sel = base_plo;
        end else if (i_acc.addr[`SWB_ADDR_HALF_BIT]) begin
          base_sel = base_phi;
        end else begin
          base_sel = base_plo;
        end
      end
      default: base_sel = base_plo;
    endcase
  end

  // Doubling keeps the count inside four bits, 14 at most
  assign waits_raw = mult ? {base_sel, 1'b0} : {1'b0, base_sel};

  // A programmed zero still costs one wait
  assign waits_nxt = (waits_raw < `SWB_MIN_WAITS) ? `SWB_MIN_WAITS : waits_raw;

  // ----------------------------------------------------------------
  // Bank-switch detection against the previous access
  // ----------------------------------------------------------------

  logic last_valid_r;
  logic last_write_r;
  swb_space_e last_space_r;
  logic [ADDR_W-1:0] last_addr_r;
  logic mem_space;
  logic bank_cross;
  logic page_cross;
  logic space_cross;
  logic turn_cross;
  logic need_idle;
  logic take;

  assign mem_space = (i_acc.space == SWB_SP_PROG) || (i_acc.space == SWB_SP_DATA);

  // Mask selects how many upper address bits define a bank
  assign bank_cross = mem_space && (i_acc.space == last_space_r) &&
    (((i_acc.addr[`SWB_ADDR_BANK_MSB:`SWB_ADDR_BANK_LSB] ^
       last_addr_r[`SWB_ADDR_BANK_MSB:`SWB_ADDR_BANK_LSB]) & bank_mask) != 4'h0);

  // Program page change or program-to-data move
  assign page_cross = (i_acc.space == SWB_SP_PROG) && (last_space_r == SWB_SP_PROG) &&
    (i_acc.addr[`SWB_ADDR_PAGE_MSB:`SWB_ADDR_PAGE_LSB] !=
     last_addr_r[`SWB_ADDR_PAGE_MSB:`SWB_ADDR_PAGE_LSB]);
  assign space_cross = (last_space_r == SWB_SP_PROG) && (i_acc.space == SWB_SP_DATA);

  // Read-to-read turnaround between data and program
  assign turn_cross = turn_en && !i_acc.write && !last_write_r && mem_space &&
    (last_space_r != SWB_SP_IO) && (i_acc.space != last_space_r);

  // Only one idle cycle however many causes coincide
  assign need_idle = last_valid_r && (bank_cross || page_cross || space_cross || turn_cross);

  // ----------------------------------------------------------------
  // Bus-cycle state machine
  // ----------------------------------------------------------------

  swb_state_e state_r;
  swb_state_e state_nxt;
  logic [3:0] cnt_r;
  logic [3:0] waits_r;

  assign take = (state_r == SWB_ST_IDLE) && i_acc.valid;

  // Next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SWB_ST_IDLE: begin
        if (take) begin
          state_nxt = need_idle ? SWB_ST_TURN : SWB_ST_STRB;
        end
      end
      SWB_ST_TURN: state_nxt = SWB_ST_STRB;
      SWB_ST_STRB: begin
        if (cnt_r == 4'h0) begin
          state_nxt = SWB_ST_IDLE;
        end
      end
      default: state_nxt = SWB_ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r <= SWB_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Wait counter, loaded when the strobe starts
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      waits_r <= 4'h0;
      cnt_r <= 4'h0;
    end else begin
      if (take) begin
        waits_r <= waits_nxt;
        cnt_r <= waits_nxt;
      end else if (state_r == SWB_ST_TURN) begin
        cnt_r <= waits_r;
      end else if ((state_r == SWB_ST_STRB) && (cnt_r != 4'h0)) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Previous-access history
  // ----------------------------------------------------------------

  // Kept across idle time so a later access still sees a crossing
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      last_valid_r <= 1'b0;
      last_write_r <= 1'b0;
      last_space_r <= SWB_SP_PROG;
      last_addr_r <= '0;
    end else if (take) begin
      last_valid_r <= 1'b1;
      last_write_r <= i_acc.write;
      last_space_r <= i_acc.space;
      last_addr_r <= i_acc.addr[ADDR_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // External bus outputs
  // ----------------------------------------------------------------

  // Address, direction and write data held for the whole access
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ext_write <= 1'b0;
      o_ext_space <= SWB_SP_PROG;
      o_ext_addr <= '0;
      o_ext_wdata <= 16'h0000;
    end else if (take) begin
      o_ext_write <= i_acc.write;
      o_ext_space <= i_acc.space;
      o_ext_addr <= i_acc.addr[ADDR_W-1:0];
      o_ext_wdata <= i_acc.wdata;
    end
  end

  // Idle flag marks the inserted dead cycle on the bus
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_idle_ins <= 1'b0;
    end else begin
      o_idle_ins <= take && need_idle;
    end
  end

  // Strobe stays high for the base cycle plus every wait
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_strobe <= 1'b0;
    end else begin
      o_strobe <= (state_nxt == SWB_ST_STRB);
    end
  end

  // ----------------------------------------------------------------
  // Completion toward the subsystem
  // ----------------------------------------------------------------

  // Busy from take until the ack edge
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= (state_nxt != SWB_ST_IDLE);
    end
  end

  // Read data sampled at the very end of the stretched cycle
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ack <= 1'b0;
      o_rdata <= 16'h0000;
    end else begin
      o_ack <= (state_r == SWB_ST_STRB) && (cnt_r == 4'h0);
      if ((state_r == SWB_ST_STRB) && (cnt_r == 4'h0) && !o_ext_write) begin
        o_rdata <= i_ext_rdata;
      end
    end
  end

endmodule // swb_wait_bank

`default_nettype wire

// ---- include/swb_consts.svh ----
`ifndef SWB_CONSTS_SVH
`define SWB_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets on the memory-mapped register port
// ----------------------------------------------------------------
`define SWB_OFS_WS_CONFIG 8'h28
`define SWB_OFS_WS_CONTROL 8'h2B
`define SWB_OFS_BANK_CTRL 8'h29

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SWB_RST_WS_CONFIG 16'h7FFF
`define SWB_RST_WS_CONTROL 16'h0000
`define SWB_RST_BANK_CTRL 16'hF800

// ----------------------------------------------------------------
// Writable bit masks
// ----------------------------------------------------------------
`define SWB_WMASK_WS_CONFIG 16'hFFFF
`define SWB_WMASK_WS_CONTROL 16'h0001
`define SWB_WMASK_BANK_CTRL 16'hF800

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SWB_CFG_EXTR_BIT 15
`define SWB_CFG_IO_MSB 14
`define SWB_CFG_IO_LSB 12
`define SWB_CFG_DHI_MSB 11
`define SWB_CFG_DHI_LSB 9
`define SWB_CFG_DLO_MSB 8
`define SWB_CFG_DLO_LSB 6
`define SWB_CFG_PHI_MSB 5
`define SWB_CFG_PHI_LSB 3
`define SWB_CFG_PLO_MSB 2
`define SWB_CFG_PLO_LSB 0
`define SWB_CTL_MULT_BIT 0
`define SWB_BSC_CMP_MSB 15
`define SWB_BSC_CMP_LSB 12
`define SWB_BSC_TURN_BIT 11

// ----------------------------------------------------------------
// Address bits used by range and boundary decoding
// ----------------------------------------------------------------
`define SWB_ADDR_HALF_BIT 15
`define SWB_ADDR_PAGE_MSB 17
`define SWB_ADDR_PAGE_LSB 16
`define SWB_ADDR_BANK_MSB 15
`define SWB_ADDR_BANK_LSB 12

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define SWB_MIN_WAITS 4'h1
`define SWB_IDLE_CYCLES 1

`endif

// ---- include/swb_pkg.sv ----
`default_nettype none

package swb_pkg;

  // Address space of an external access
  typedef enum logic [1:0] {
    SWB_SP_PROG = 2'h0,
    SWB_SP_DATA = 2'h1,
    SWB_SP_IO = 2'h2
  } swb_space_e;

  // External access request from the granted subsystem
  typedef struct packed {
    logic valid;
    logic write;
    swb_space_e space;
    logic [17:0] addr;
    logic [15:0] wdata;
  } swb_acc_s;

  // Memory-mapped register port of one subsystem
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } swb_reg_req_s;

  // Register contents of one subsystem
  typedef struct packed {
    logic [15:0] ws_config;
    logic [15:0] ws_control;
    logic [15:0] bank_ctrl;
  } swb_regset_s;

  // Bus-cycle controller states
  typedef enum logic [2:0] {
    SWB_ST_IDLE = 3'b001,
    SWB_ST_TURN = 3'b010,
    SWB_ST_STRB = 3'b100
  } swb_state_e;

endpackage : swb_pkg

`default_nettype wire

// ---- sim/swb_checker.sv ----
`default_nettype none

module swb_checker
  import swb_pkg::*;
#(
  parameter int ADDR_W = 18
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Access side
  input wire swb_acc_s i_acc,
  input wire logic o_busy,
  input wire logic o_ack,
  input wire logic [15:0] o_rdata,
  // External bus
  input wire logic o_strobe,
  input wire logic o_idle_ins,
  input wire logic o_ext_write,
  input wire logic [ADDR_W-1:0] o_ext_addr,
  input wire logic [15:0] i_ext_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Strobe run length
  // ----------------------------------------------------------------
  logic [4:0] run_r;

  // Cycles the strobe has stood so far; a plain repeat would not reach 15
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      run_r <= 5'h00;
    end else begin
      run_r <= o_strobe ? run_r + 5'h01 : 5'h00;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  strobe_max_a: assert property (run_r <= 5'h0F)
    else $error("strobe longer than fourteen waits");
  strobe_min_a: assert property ($rose(o_strobe) |=> o_strobe)
    else $error("strobe shorter than one wait");
  ack_end_a: assert property (o_ack |-> !o_strobe && !o_busy && $past(o_strobe))
    else $error("ack not right after strobe");
  ack_pulse_a: assert property (o_ack |=> !o_ack)
    else $error("ack longer than one cycle");
  busy_done_a: assert property ($fell(o_busy) |-> o_ack)
    else $error("busy fell without ack");
  idle_lead_a: assert property (o_idle_ins |=> o_strobe && !o_idle_ins)
    else $error("idle cycle not followed by strobe");
  take_start_a: assert property (i_acc.valid && !o_busy |=> o_busy && (o_strobe ^ o_idle_ins))
    else $error("access not started after take");
  addr_hold_a: assert property (o_busy && $past(o_busy) |-> $stable(o_ext_addr))
    else $error("address moved in a cycle");
  read_data_a: assert property (o_ack && !o_ext_write |-> o_rdata == $past(i_ext_rdata))
    else $error("read data not from last strobe cycle");

  idle_seen_c: cover property (o_idle_ins);
  max_run_c: cover property (run_r == 5'h0F);
  read_done_c: cover property (o_ack && !o_ext_write);
endmodule // swb_checker

bind swb_wait_bank swb_checker #(.ADDR_W(ADDR_W)) u_chk (
  .i_clk(i_clk),
  .i_resetn(i_resetn),
  .i_acc(i_acc),
  .o_busy(o_busy),
  .o_ack(o_ack),
  .o_rdata(o_rdata),
  .o_strobe(o_strobe),
  .o_idle_ins(o_idle_ins),
  .o_ext_write(o_ext_write),
  .o_ext_addr(o_ext_addr),
  .i_ext_rdata(i_ext_rdata)
);

`default_nettype wire

// ---- sim/swb_ext_mem.sv ----
`default_nettype none

module swb_ext_mem (
  // External bus from the device
  input wire logic i_clk,
  input wire logic i_strobe,
  input wire logic i_write,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  // Read data back
  output logic [15:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] mem [16];

  // Slow part: data valid one cycle into the strobe, junk outside it
  always @(posedge i_clk) begin
    if (i_strobe && i_write)
      mem[i_addr] <= i_wdata;
    o_rdata <= (i_strobe && !i_write) ? mem[i_addr] : ~o_rdata;
  end

  // Known contents so reads can be predicted
  initial begin
    o_rdata = 16'h0000;
    for (int i = 0; i < 16; i++)
      mem[i] = 16'hC000 + 16'(i);
  end
endmodule // swb_ext_mem

`default_nettype wire

// ---- sim/tb_external_bus_wait_state_bank_switch.sv ----
`default_nettype none

module tb_external_bus_wait_state_bank_switch
  import swb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam swb_space_e P = SWB_SP_PROG;
  localparam swb_space_e D = SWB_SP_DATA;
  localparam swb_space_e I = SWB_SP_IO;
  logic i_clk, i_resetn, i_subsys_sel, busy, ack, strobe, idle, ext_wr;
  swb_reg_req_s a_reg, b_reg;
  swb_acc_s acc;
  swb_space_e ext_sp;
  logic [17:0] ext_addr;
  logic [15:0] a_rd, b_rd, rdata, ext_wd, ext_rd;
  logic [15:0] mem [16];
  int err_count, check_count;

  swb_wait_bank DUT (.i_clk(i_clk), .i_resetn(i_resetn), .i_subsys_sel(i_subsys_sel),
    .i_a_reg(a_reg), .o_a_rdata(a_rd), .i_b_reg(b_reg), .o_b_rdata(b_rd),
    .i_acc(acc), .o_busy(busy), .o_ack(ack), .o_rdata(rdata), .o_strobe(strobe),
    .o_idle_ins(idle), .o_ext_write(ext_wr), .o_ext_space(ext_sp),
    .o_ext_addr(ext_addr), .o_ext_wdata(ext_wd), .i_ext_rdata(ext_rd));

  swb_ext_mem u_mem (.i_clk(i_clk), .i_strobe(strobe), .i_write(ext_wr),
    .i_addr(ext_addr[3:0]), .i_wdata(ext_wd), .o_rdata(ext_rd));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(string nm, logic [15:0] ex, logic [15:0] got);
    check_count++;
    if (got !== ex) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic rw(bit b, logic [7:0] ad, logic [15:0] d);
    @(posedge i_clk);
    if (b)
      b_reg <= '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: d};
    else
      a_reg <= '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: d};
    @(posedge i_clk);
    a_reg <= '0;
    b_reg <= '0;
  endtask

  task automatic rr(bit b, logic [7:0] ad, logic [15:0] ex);
    @(posedge i_clk);
    if (b)
      b_reg <= '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 16'h0000};
    else
      a_reg <= '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 16'h0000};
    @(posedge i_clk);
    a_reg <= '0;
    b_reg <= '0;
    #1;
    chk("register", ex, b ? b_rd : a_rd);
  endtask

  // One access; wt is the wait count, id the expected idle cycles
  task automatic ac(swb_space_e sp, logic [17:0] ad, bit w, int wt, int id);
    int s;
    int n;
    int b;
    logic [15:0] wd;
    s = 0;
    n = 0;
    b = 0;
    wd = 16'h5A00 ^ ad[15:0];
    @(posedge i_clk);
    acc <= '{valid: 1'b1, write: w, space: sp, addr: ad, wdata: wd};
    @(posedge i_clk);
    acc.valid <= 1'b0;
    // Count from the take edge on; the first strobe or idle cycle starts there
    #1;
    for (int k = 0; k < 20 && ack !== 1'b1; k++) begin
      s += int'(strobe === 1'b1);
      n += int'(idle === 1'b1);
      b += int'(busy === 1'b1);
      @(posedge i_clk);
      #1;
    end
    chk("ack seen", 16'h0001, 16'(ack));
    chk("strobe cycles", 16'(wt + 1), 16'(s));
    chk("idle cycles", 16'(id), 16'(n));
    chk("busy cycles", 16'(wt + 1 + id), 16'(b));
    chk("bus space", 16'(sp), 16'(ext_sp));
    if (w)
      mem[ad[3:0]] = wd;
    else
      chk("read data", mem[ad[3:0]], rdata);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rr(0, 8'h28, 16'h7FFF);
    rr(0, 8'h2B, 16'h0000);
    rr(0, 8'h29, 16'hF800);
    rr(0, 8'h30, 16'h0000);
    ac(D, 18'h00100, 0, 7, 0);
    rw(0, 8'h29, 16'h0000);
  endtask

  task automatic t_fields();
    rw(0, 8'h28, 16'h3AB0);
    ac(D, 18'h08000, 0, 5, 0);
    ac(D, 18'h07FFF, 1, 2, 0);
    ac(I, 18'h01234, 0, 3, 0);
    ac(P, 18'h08000, 0, 6, 0);
    ac(P, 18'h00010, 0, 1, 0);
    ac(P, 18'h18000, 0, 6, 1);
    ac(D, 18'h00100, 0, 2, 1);
    ac(D, 18'h0000F, 0, 2, 0);
  endtask

  task automatic t_mult();
    rw(0, 8'h2B, 16'hFFFF);
    rr(0, 8'h2B, 16'h0001);
    rw(0, 8'h28, 16'hF007);
    ac(I, 18'h0FFFF, 0, 14, 0);
    ac(P, 18'h28000, 0, 14, 0);
    ac(D, 18'h08000, 0, 1, 1);
    rw(0, 8'h2B, 16'h0000);
    ac(I, 18'h00000, 0, 7, 0);
    ac(D, 18'h08000, 0, 1, 0);
  endtask

  task automatic t_bank();
    rw(0, 8'h28, 16'h0000);
    rw(0, 8'h29, 16'hFFFF);
    rr(0, 8'h29, 16'hF800);
    rw(0, 8'h29, 16'hF000);
    ac(D, 18'h01000, 0, 1, 1);
    ac(D, 18'h01FFF, 0, 1, 0);
    rw(0, 8'h29, 16'h8000);
    ac(D, 18'h07000, 0, 1, 0);
    rw(0, 8'h29, 16'h0800);
    ac(P, 18'h00000, 0, 1, 1);
    ac(D, 18'h07000, 0, 1, 1);
    rw(0, 8'h29, 16'h0000);
    ac(P, 18'h00000, 0, 1, 0);
  endtask

  task automatic t_sel();
    rw(1, 8'h28, 16'h0100);
    rw(1, 8'h29, 16'hF000);
    rr(1, 8'h28, 16'h0100);
    @(posedge i_clk);
    i_subsys_sel <= 1'b1;
    ac(D, 18'h00200, 0, 4, 1);
    ac(D, 18'h03000, 0, 4, 1);
    @(posedge i_clk);
    i_subsys_sel <= 1'b0;
    ac(D, 18'h05000, 0, 1, 0);
  endtask

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // 100 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // Main sequence
  initial begin
    i_resetn = 1'b0;
    i_subsys_sel = 1'b0;
    a_reg = '0;
    b_reg = '0;
    acc = '0;
    err_count = 0;
    check_count = 0;
    for (int i = 0; i < 16; i++)
      mem[i] = 16'hC000 + 16'(i);
    repeat (6) @(posedge i_clk);
    i_resetn <= 1'b1;
    t_reset();
    t_fields();
    t_mult();
    t_bank();
    t_sel();
    conclude();
  end

  // Tests need about 210 cycles; 5000 leaves margin without hiding a hang
  initial begin
    #50000;
    err_count++;
    conclude();
  end
endmodule // tb_external_bus_wait_state_bank_switch

`default_nettype wire
